//--- logic/lcr_cell.sv
// Logic cell used as distributed RAM, configured over APB
`default_nettype none

module lcr_cell (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [lcr_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Fabric side, same clock as the cell
  input  wire logic [lcr_pkg::ADDR_W-1:0]  first_table_inputs,
  input  wire logic [lcr_pkg::ADDR_W-1:0]  second_table_inputs,
  input  wire logic                        cell_direct_input,
  input  wire logic                        cell_aux_input,
  input  wire logic                        cell_setreset_input,
  output logic                             first_read_output,
  output logic                             second_read_output,
  output logic                             first_captured_q,
  output logic                             second_captured_q
);

  // Configuration and status state
  lcr_pkg::lcr_mode_e                cfg_mode_q;
  lcr_pkg::lcr_mode_e                cfg_mode_d;
  logic                              cfg_level_q;
  logic                              cfg_level_d;
  logic [lcr_pkg::LOGIC_W-1:0]       logic_table_q;
  logic [lcr_pkg::LOGIC_W-1:0]       logic_table_d;
  logic [lcr_pkg::WCNT_W-1:0]        wcount_q;
  logic [lcr_pkg::WCNT_W-1:0]        wcount_d;
  logic                              first_captured_d;
  logic                              second_captured_d;

  // Renamed control pins while the tables act as memory
  wire logic                         data_in_low;
  wire logic                         data_in_high_or_addr_bit4;
  wire logic                         write_enable;
  wire logic [lcr_pkg::ADDR_W-1:0]   second_read_address;

  // Mode decode
  wire logic                         mode_two16;
  wire logic                         mode_wide32;
  wire logic                         mode_dual;
  wire logic                         mode_half;
  wire logic                         level_eff;
  wire logic                         timing_conflict;

  // Table connections
  wire logic [lcr_pkg::ADDR_W-1:0]   f_addr;
  wire logic [lcr_pkg::ADDR_W-1:0]   g_wr_addr;
  wire logic [lcr_pkg::ADDR_W-1:0]   g_rd_addr;
  wire logic                         f_wr_en;
  wire logic                         g_wr_en;
  wire logic                         f_wr_data;
  wire logic                         g_wr_data;
  wire logic                         f_out;
  wire logic                         g_out;
  wire logic                         wide_out;
  wire logic                         spare_out;
  wire logic [4:0]                   spare_index;
  wire logic                         edge_write;

  // APB decode
  wire logic                         apb_access;
  wire logic                         apb_wr;
  wire logic                         apb_rd;
  wire logic                         hit_cfg;
  wire logic                         hit_logic;
  wire logic                         hit_status;
  wire logic                         hit_wcount;
  wire logic                         hit_any;
  wire logic                         cfg_we;
  wire logic                         logic_we;
  wire logic                         wcount_clr;
  logic      [31:0]                  cfg_word;
  logic      [31:0]                  status_word;
  wire logic [31:0]                  rd_mux;

  // Cell control pins take their memory meaning
  assign data_in_low               = cell_direct_input;
  assign data_in_high_or_addr_bit4 = cell_aux_input;
  assign write_enable              = cell_setreset_input;
  // The second table inputs carry the separate read address in dual-port
  assign second_read_address       = second_table_inputs;

  // Mode decode from the configuration register
  assign mode_two16  = (cfg_mode_q == lcr_pkg::LCR_MODE_TWO16);
  assign mode_wide32 = (cfg_mode_q == lcr_pkg::LCR_MODE_WIDE32);
  assign mode_dual   = (cfg_mode_q == lcr_pkg::LCR_MODE_DUALPORT);
  assign mode_half   = (cfg_mode_q == lcr_pkg::LCR_MODE_HALF);

  // One timing bit serves both tables, so they can never differ
  // Dual-port overrides a level request: its write port is edge only
  assign level_eff       = cfg_level_q && !mode_dual;
  // Flag the ignored level request so software can see it
  assign timing_conflict = cfg_level_q && mode_dual;

  // First table address: its own inputs in every mode
  assign f_addr = first_table_inputs;

  // Second table write address: own inputs, or the first address when
  // the two tables act as one array
  assign g_wr_addr = (mode_wide32 || mode_dual) ? first_table_inputs
                                                : second_table_inputs;

  // Second table read address: separate port only in dual-port
  assign g_rd_addr = mode_dual   ? second_read_address
                   : mode_wide32 ? first_table_inputs
                   : second_table_inputs;

  // Write steering per arrangement
  // Two16: each table has its own data bit
  // Wide32: bit four picks the table, data low is the data
  // Dual: both tables written together from data low
  // Half: only the first table is memory
  assign f_wr_en = write_enable &&
                   (mode_two16 || mode_dual || mode_half ||
                    (mode_wide32 && !data_in_high_or_addr_bit4));
  assign g_wr_en = write_enable &&
                   (mode_two16 || mode_dual ||
                    (mode_wide32 && data_in_high_or_addr_bit4));
  assign f_wr_data = data_in_low;
  assign g_wr_data = mode_two16 ? data_in_high_or_addr_bit4
                                : data_in_low;

  // First table
  lcr_table u_first (
    .pclk       (pclk),
    .clk_en     (clk_en),
    .level_mode (level_eff),
    .wr_en      (f_wr_en),
    .wr_addr    (f_addr),
    .rd_addr    (f_addr),
    .wr_data    (f_wr_data),
    .rd_data    (f_out)
  );

  // Second table; in dual-port its write and read addresses differ,
  // so a write and a read proceed in the same cycle
  lcr_table u_second (
    .pclk       (pclk),
    .clk_en     (clk_en),
    .level_mode (level_eff),
    .wr_en      (g_wr_en),
    .wr_addr    (g_wr_addr),
    .rd_addr    (g_rd_addr),
    .wr_data    (g_wr_data),
    .rd_data    (g_out)
  );

  // Wide32 output: bit four selects which half answers
  assign wide_out = data_in_high_or_addr_bit4 ? g_out : f_out;

  // Spare five-input function from the truth table register
  // Index is the second table inputs plus the aux input as top bit
  assign spare_index = {data_in_high_or_addr_bit4, second_table_inputs};
  assign spare_out   = logic_table_q[spare_index];

  // Outputs come from the tables, the spare function or a constant zero, with no clock in the path
  assign first_read_output  = mode_wide32 ? wide_out : f_out;
  assign second_read_output = mode_half   ? spare_out
                            : mode_wide32 ? 1'b0
                            : g_out;

  // Cell flops capture the same outputs on each enabled edge
  assign first_captured_d  = first_read_output;
  assign second_captured_d = second_read_output;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_captured_q  <= 1'b0;
      second_captured_q <= 1'b0;
    end else if (clk_en) begin
      first_captured_q  <= first_captured_d;
      second_captured_q <= second_captured_d;
    end
  end

  // Edge writes are counted so software can watch traffic; level writes
  // have no clock of their own and are not counted
  assign edge_write = clk_en && !level_eff && (f_wr_en || g_wr_en);

  // APB access phase; clk_en low stalls the bus through pready
  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite && clk_en;
  assign apb_rd     = apb_access && !pwrite;

  // Address decode on full word addresses
  assign hit_cfg    = (paddr == lcr_pkg::OFS_CFG);
  assign hit_logic  = (paddr == lcr_pkg::OFS_LOGIC);
  assign hit_status = (paddr == lcr_pkg::OFS_STATUS);
  assign hit_wcount = (paddr == lcr_pkg::OFS_WCOUNT);
  assign hit_any    = hit_cfg || hit_logic || hit_status || hit_wcount;

  // One write strobe per writable word, none for status; the bus is stalled while frozen
  assign cfg_we     = apb_wr && hit_cfg;
  assign logic_we   = apb_wr && hit_logic;
  assign wcount_clr = apb_wr && hit_wcount;

  // Configuration next values
  assign cfg_mode_d = cfg_we
      ? lcr_pkg::lcr_mode_e'(
          pwdata[lcr_pkg::CFG_MODE_MSB:lcr_pkg::CFG_MODE_LSB])
      : cfg_mode_q;
  assign cfg_level_d = cfg_we
                     ? pwdata[lcr_pkg::CFG_LEVEL_BIT]
                     : cfg_level_q;
  assign logic_table_d = logic_we ? pwdata : logic_table_q;

  // Writing the counter clears it; a write edge in the same cycle still
  // counts, so no event is lost to the clear
  assign wcount_d = (wcount_clr ? lcr_pkg::WCNT_RESET
                                : wcount_q)
                  + (edge_write ? lcr_pkg::WCNT_ONE : lcr_pkg::WCNT_RESET);

  // Register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_mode_q    <= lcr_pkg::CFG_MODE_RESET;
      cfg_level_q   <= lcr_pkg::CFG_LEVEL_RESET;
      logic_table_q <= lcr_pkg::LOGIC_RESET;
      wcount_q      <= lcr_pkg::WCNT_RESET;
    end else if (clk_en) begin
      cfg_mode_q    <= cfg_mode_d;
      cfg_level_q   <= cfg_level_d;
      logic_table_q <= logic_table_d;
      wcount_q      <= wcount_d;
    end
  end

  // Configuration read-back; reserved bits read as zero
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[lcr_pkg::CFG_MODE_MSB:lcr_pkg::CFG_MODE_LSB] = cfg_mode_q;
    cfg_word[lcr_pkg::CFG_LEVEL_BIT] = cfg_level_q;
  end

  // Status read-back; field positions live in the package only
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[lcr_pkg::STS_FIRST_BIT]    = first_read_output;
    status_word[lcr_pkg::STS_SECOND_BIT]   = second_read_output;
    status_word[lcr_pkg::STS_LEVEL_BIT]    = level_eff;
    status_word[lcr_pkg::STS_CONFLICT_BIT] = timing_conflict;
    status_word[lcr_pkg::STS_XCAP_BIT]     = first_captured_q;
    status_word[lcr_pkg::STS_YCAP_BIT]     = second_captured_q;
  end

  // Read mux, zero for unmapped addresses and outside a read
  assign rd_mux = hit_cfg    ? cfg_word
                : hit_logic  ? logic_table_q
                : hit_status ? status_word
                : hit_wcount ? {16'h0000, wcount_q}
                : 32'h0000_0000;

  // Zero-wait slave while enabled; an unmapped address is an error
  assign prdata  = apb_rd ? rd_mux : 32'h0000_0000;
  assign pready  = clk_en;
  assign pslverr = apb_access && clk_en && !hit_any;

endmodule

`default_nettype wire

//--- logic/lcr_pkg.sv
// Shared constants and the single lookup-table storage leaf of the cell RAM
`default_nettype none

package lcr_pkg;
  // Table geometry
  localparam int ADDR_W  = 4;
  localparam int DEPTH   = 16;
  localparam int WCNT_W  = 16;
  localparam int LOGIC_W = 32;

  // Memory arrangement of the two tables
  typedef enum logic [1:0] {
    LCR_MODE_TWO16,
    LCR_MODE_WIDE32,
    LCR_MODE_DUALPORT,
    LCR_MODE_HALF
  } lcr_mode_e;

  // APB map, byte addresses
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] OFS_CFG    = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_LOGIC  = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_WCOUNT = 8'h0C;

  // Configuration register fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_MODE_MSB  = 1;
  localparam int CFG_LEVEL_BIT = 2;
  localparam lcr_mode_e CFG_MODE_RESET  = LCR_MODE_TWO16;
  localparam logic      CFG_LEVEL_RESET = 1'b0;

  // Truth table of the spare logic function
  localparam logic [LOGIC_W-1:0] LOGIC_RESET = 32'h0000_0000;

  // Status register fields
  localparam int STS_FIRST_BIT    = 0;
  localparam int STS_SECOND_BIT   = 1;
  localparam int STS_LEVEL_BIT    = 2;
  localparam int STS_CONFLICT_BIT = 3;
  localparam int STS_XCAP_BIT     = 4;
  localparam int STS_YCAP_BIT     = 5;

  localparam logic [WCNT_W-1:0] WCNT_RESET = 16'h0000;
  localparam logic [WCNT_W-1:0] WCNT_ONE   = 16'h0001;
endpackage

// One 16x1 table: edge-written flops plus level-written latches
module lcr_table (
  input  wire logic                       pclk,
  input  wire logic                       clk_en,
  input  wire logic                       level_mode,
  input  wire logic                       wr_en,
  input  wire logic [lcr_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [lcr_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic                       wr_data,
  output logic                            rd_data
);
  logic [lcr_pkg::DEPTH-1:0] edge_bits;
  logic [lcr_pkg::DEPTH-1:0] level_bits;

  // Contents are never reset; switching timing mode exposes the other bank
  genvar i;
  generate
    for (i = 0; i < lcr_pkg::DEPTH; i++) begin : g_entry
      logic hit;
      logic edge_q;
      logic level_q;
      assign hit = (wr_addr == lcr_pkg::ADDR_W'(i));
      // Edge write: clock edge only, enable acts as clock enable
      always_ff @(posedge pclk) begin
        if (clk_en && !level_mode && wr_en && hit) begin
          edge_q <= wr_data;
        end
      end
      // Level write: transparent while the strobe is high
      always_latch begin
        if (clk_en && level_mode && wr_en && hit) begin
          level_q <= wr_data;
        end
      end
      assign edge_bits[i]  = edge_q;
      assign level_bits[i] = level_q;
    end
  endgenerate

  // Same combinational read path in both timing modes
  assign rd_data = level_mode ? level_bits[rd_addr]
                              : edge_bits[rd_addr];
endmodule

`default_nettype wire

//--- sim/lcr_cell_assertions.sv
// Port-level property checker for the cell RAM, bound into lcr_cell
`default_nettype none
module lcr_cell_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [3:0]  first_table_inputs,
  input wire logic [3:0]  second_table_inputs,
  input wire logic        cell_direct_input,
  input wire logic        cell_aux_input,
  input wire logic        cell_setreset_input,
  input wire logic        first_read_output,
  input wire logic        second_read_output,
  input wire logic        first_captured_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q;
  logic       level_q;
  logic       wr_ev;
  logic       two16;
  logic       wide;
  logic       dual;
  // Shadow of the mode field; tables keep no reset, so table checks use ===
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= lcr_pkg::CFG_MODE_RESET;
      level_q <= lcr_pkg::CFG_LEVEL_RESET;
    end else if (psel && penable && pready && pwrite &&
                 paddr == lcr_pkg::OFS_CFG) begin
      mode_q  <= pwdata[lcr_pkg::CFG_MODE_MSB:lcr_pkg::CFG_MODE_LSB];
      level_q <= pwdata[lcr_pkg::CFG_LEVEL_BIT];
    end
  end
  // Mode decode and write event
  assign wr_ev = clk_en && cell_setreset_input;
  assign two16 = mode_q == lcr_pkg::LCR_MODE_TWO16 && !level_q;
  assign wide  = mode_q == lcr_pkg::LCR_MODE_WIDE32;
  assign dual  = mode_q == lcr_pkg::LCR_MODE_DUALPORT;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_two_first;
    (two16 && wr_ev) ##1 $stable(first_table_inputs)
      |-> first_read_output === $past(cell_direct_input);
  endproperty
  a_two_first: assert property (p_two_first)
    else $error("first table missed an edge write");
  property p_two_second;
    (two16 && wr_ev) ##1 $stable(second_table_inputs)
      |-> second_read_output === $past(cell_aux_input);
  endproperty
  a_two_second: assert property (p_two_second)
    else $error("second table missed an edge write");
  property p_hold;
    (two16 && !wr_ev) ##1 ($stable(first_table_inputs) && $stable(mode_q))
      |-> first_read_output === $past(first_read_output);
  endproperty
  a_hold: assert property (p_hold)
    else $error("first table changed without write enable");
  property p_wide_first;
    (wide && wr_ev) ##1 ($stable(first_table_inputs) &&
      $stable(cell_aux_input))
      |-> first_read_output === $past(cell_direct_input);
  endproperty
  a_wide_first: assert property (p_wide_first)
    else $error("wide array missed an edge write");
  property p_wide_second;
    wide |-> second_read_output == 1'b0;
  endproperty
  a_wide_second: assert property (p_wide_second)
    else $error("second output not low in wide arrangement");
  property p_dp_first;
    (dual && wr_ev) ##1 $stable(first_table_inputs)
      |-> first_read_output === $past(cell_direct_input);
  endproperty
  a_dp_first: assert property (p_dp_first)
    else $error("dual-port first read missed the write");
  property p_dp_second;
    (dual && wr_ev) ##1
      (second_table_inputs == $past(first_table_inputs))
      |-> second_read_output === $past(cell_direct_input);
  endproperty
  a_dp_second: assert property (p_dp_second)
    else $error("dual-port second read missed the write");
  property p_cap;
    // The release edge still resets the flop, so start after it
    (clk_en && presetn) |=> first_captured_q === $past(first_read_output);
  endproperty
  a_cap: assert property (p_cap)
    else $error("captured flop did not follow first output");
endmodule

bind lcr_cell lcr_cell_chk chk_u (.*);
`default_nettype wire

//--- sim/lcr_fabric_model.sv
// Fabric user logic that drives the memory side of the cell
`default_nettype none
module lcr_fabric_model (
  input  wire logic       pclk,
  output var  logic [3:0] first_table_inputs,
  output var  logic [3:0] second_table_inputs,
  output var  logic       cell_direct_input,
  output var  logic       cell_aux_input,
  output var  logic       cell_setreset_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet, known levels before the first request
  initial begin
    first_table_inputs  = 4'h0;
    second_table_inputs = 4'h0;
    cell_direct_input   = 1'b0;
    cell_aux_input      = 1'b0;
    cell_setreset_input = 1'b0;
  end
  // One fabric cycle: every line moves just after the clock edge
  task automatic drive(input logic [3:0] a, b, input logic d, h, w);
    @(posedge pclk);
    first_table_inputs  <= a;
    second_table_inputs <= b;
    cell_direct_input   <= d;
    cell_aux_input      <= h;
    cell_setreset_input <= w;
  endtask
  // Enable for one edge; the write lands on the second edge
  task automatic edge_wr(input logic [3:0] a, b, input logic d, h);
    drive(a, b, d, h, 1'b1);
    drive(a, b, d, h, 1'b0);
    // Let the read path settle before the caller looks
    #1;
  endtask
  // Latch write: lines settle before the strobe and stay after it
  task automatic lvl_wr(input logic [3:0] a, b, input logic d, h);
    drive(a, b, d, h, 1'b0);
    drive(a, b, d, h, 1'b1);
    drive(a, b, d, h, 1'b0);
    #1;
  endtask
endmodule
`default_nettype wire

//--- sim/logic_cell_lut_ram_tb.sv
// Self-checking bench for the logic cell distributed RAM
`default_nettype none
module logic_cell_lut_ram_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'hA5C3_0F96;
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, slv;
  logic [3:0]  first_table_inputs, second_table_inputs;
  logic        cell_direct_input, cell_aux_input, cell_setreset_input;
  logic        first_read_output, second_read_output;
  logic        first_captured_q, second_captured_q;
  int          error_cnt = 0;
  int          checks_done = 0;

  lcr_cell         dut_u (.*);
  lcr_fabric_model fab_u (.*);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] outs();
    return {30'h0, second_read_output, first_read_output};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic look(input logic [3:0] a, b, input logic h);
    fab_u.drive(a, b, 1'b0, h, 1'b0);
    #1;
  endtask

  task automatic t_two16();
    apb(1'b0, lcr_pkg::OFS_CFG, 32'h0);
    chk(rd, 32'h0, "cfg reset");
    apb(1'b1, lcr_pkg::OFS_WCOUNT, 32'h0);
    fab_u.edge_wr(4'h5, 4'h9, 1'b1, 1'b0);
    chk(outs(), 32'h1, "two16 first");
    fab_u.edge_wr(4'h5, 4'h9, 1'b0, 1'b1);
    chk(outs(), 32'h2, "two16 second");
    fab_u.drive(4'h5, 4'h9, 1'b1, 1'b0, 1'b0);
    fab_u.drive(4'h5, 4'h9, 1'b1, 1'b0, 1'b0);
    #1;
    chk(outs(), 32'h2, "two16 no enable");
    apb(1'b0, lcr_pkg::OFS_WCOUNT, 32'h0);
    chk(rd, 32'h2, "write count");
    apb(1'b0, lcr_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h22, "two16 status");
    $display("end two16");
  endtask
  task automatic t_wide();
    apb(1'b1, lcr_pkg::OFS_CFG, 32'h1);
    fab_u.edge_wr(4'h3, 4'h0, 1'b1, 1'b0);
    fab_u.edge_wr(4'h3, 4'h0, 1'b0, 1'b1);
    chk(outs(), 32'h0, "wide upper");
    look(4'h3, 4'h0, 1'b0);
    chk(outs(), 32'h1, "wide lower");
    $display("end wide32");
  endtask
  task automatic t_level();
    apb(1'b1, lcr_pkg::OFS_CFG, 32'h4);
    fab_u.lvl_wr(4'h7, 4'h2, 1'b1, 1'b1);
    chk(outs(), 32'h3, "level both");
    fab_u.lvl_wr(4'h7, 4'h2, 1'b0, 1'b1);
    chk(outs(), 32'h2, "level again");
    apb(1'b0, lcr_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h26, "level status");
    $display("end level");
  endtask
  task automatic t_dual();
    apb(1'b1, lcr_pkg::OFS_CFG, 32'h6);
    apb(1'b0, lcr_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[3]}, 32'h1, "conflict flag");
    fab_u.edge_wr(4'h3, 4'h8, 1'b1, 1'b0);
    fab_u.edge_wr(4'h8, 4'h3, 1'b0, 1'b0);
    chk(outs(), 32'h2, "dual write and read");
    look(4'h3, 4'h8, 1'b0);
    chk(outs(), 32'h1, "dual split read");
    fab_u.edge_wr(4'h8, 4'h8, 1'b1, 1'b0);
    chk(outs(), 32'h3, "dual same address");
    $display("end dual");
  endtask
  task automatic t_half();
    int i;
    apb(1'b1, lcr_pkg::OFS_LOGIC, PAT);
    apb(1'b0, lcr_pkg::OFS_LOGIC, 32'h0);
    chk(rd, PAT, "logic readback");
    apb(1'b1, lcr_pkg::OFS_CFG, 32'h3);
    fab_u.edge_wr(4'h6, 4'h0, 1'b1, 1'b0);
    for (i = 1; i < 32; i += 5) begin
      look(4'h6, i[3:0], i[4]);
      chk(outs(), {30'h0, PAT[i], 1'b1}, "half function");
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, slv}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    $display("end half");
  endtask
  // Clock enable low: no write lands, bus stalls, count stays put
  task automatic t_freeze();
    @(posedge pclk);
    clk_en <= 1'b0;
    fab_u.edge_wr(4'h6, 4'h0, 1'b0, 1'b0);
    chk(outs(), {30'h0, PAT[0], 1'b1}, "frozen write");
    chk({31'h0, pready}, 32'h0, "stalled ready");
    @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, lcr_pkg::OFS_WCOUNT, 32'h0);
    chk(rd, 32'h8, "edge write total");
    $display("end freeze");
  endtask

  // Main sequence: reset, then every arrangement in turn
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_two16();
    t_wide();
    t_level();
    t_dual();
    t_half();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire
